// file: hw/hsfs_oc_if.sv
// Purpose: Carrier between supervisor and overcurrent integrator
// Assumes: Single clock domain
// Notes:   fault is a one-cycle pulse
`timescale 1ns/1ps
interface hsfs_oc_if;
	logic                        overCurrent;
	logic                        clear;
	logic                        fault;
	logic [hsfs_pkg::CNT_W-1:0]  count;
	modport ctrl  (output overCurrent, output clear, input fault, input count);
	modport integ (input overCurrent, input clear, output fault, output count);
endinterface : hsfs_oc_if

// file: hw/hsfs_oc_integrator.sv
// Purpose: Up/down overcurrent time integrator with slow decay
// Assumes: overCurrent already synchronised
// Notes:   Tick runs free; any overcurrent inside a tick counts as that tick
`timescale 1ns/1ps
module hsfs_oc_integrator #(
	parameter int TICK_CYC = hsfs_pkg::TICK_SHORT_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	hsfs_oc_if.integ oc
);
	import hsfs_pkg::*;

	logic [TICK_W-1:0]  tickCnt;
	logic               tick;
	logic               pending;
	logic               hit;
	logic [DECAY_W-1:0] decayCnt;

	// Free running tick prescaler
	assign tick = (tickCnt == TICK_W'(TICK_CYC - 1));
	always_ff @(posedge clk) begin
		if (!rst_b || tick) begin
			tickCnt <= '0;
		end else begin
			tickCnt <= tickCnt + 1'b1;
		end
	end

	// Remember a short overcurrent until the tick closes
	assign hit = pending | oc.overCurrent; // [R4]
	always_ff @(posedge clk) begin
		if (!rst_b || tick) begin
			pending <= 1'b0;
		end else if (oc.overCurrent) begin
			pending <= 1'b1;
		end
	end

	// Count up one per tick with overcurrent, down once per 128 quiet ticks
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			oc.count <= '0;
			decayCnt <= '0;
			oc.fault <= 1'b0;
		end else begin
			oc.fault <= 1'b0;
			if (oc.clear) begin
				oc.count <= '0;
				decayCnt <= '0;
			end else if (tick && hit) begin
				decayCnt <= '0;
				if (oc.count == CNT_W'(LIMIT_TICKS - 1)) begin
					oc.fault <= 1'b1; // [R5] [R7]
					oc.count <= '0; // [R17]
				end else begin
					oc.count <= oc.count + 1'b1; // [R3]
				end
			end else if (tick) begin
				decayCnt <= decayCnt + 1'b1;
				if (decayCnt == DECAY_W'(DECAY_RATIO - 1) && oc.count != '0) begin
					oc.count <= oc.count - 1'b1; // [R6] [R17]
				end
			end
		end
	end
endmodule : hsfs_oc_integrator

// file: hw/hsfs_pkg.sv
// Purpose: Shared constants and types of the hot-swap fault supervisor
// Assumes: 100 MHz system clock
// Notes:   Timing figures are kept in their own unit, cycle counts derive from them
package hsfs_pkg;
	// Clock rate
	localparam int CLK_MHZ        = 100;
	// Overcurrent integrator timing
	localparam int TICK_SHORT_US  = 32;
	localparam int TICK_LONG_US   = 128;
	localparam int LIMIT_SHORT_US = 500;
	localparam int LIMIT_LONG_US  = 2000;
	localparam int TICK_SHORT_CYC = TICK_SHORT_US * CLK_MHZ;
	localparam int TICK_LONG_CYC  = TICK_LONG_US * CLK_MHZ;
	// Ticks to reach the limit, rounded up so the limit is really reached
	localparam int LIMIT_TICKS    = (LIMIT_SHORT_US + TICK_SHORT_US - 1) / TICK_SHORT_US;
	localparam int DECAY_RATIO    = 128;
	localparam int CNT_W          = 5;
	localparam int DECAY_W        = 7;
	localparam int TICK_W         = 16;
	// Cool-down and restart delay, plain defaults
	localparam int COOL_US        = 1000;
	localparam int RESTART_US     = 1000;
	localparam int COOL_CYC       = COOL_US * CLK_MHZ;
	localparam int RESTART_CYC    = RESTART_US * CLK_MHZ;
	localparam int TIMER_W        = 32;
	// Register bus
	localparam int AXI_AW         = 8;
	localparam int AXI_DW         = 32;
	localparam logic [AXI_AW-1:0] REG_CTRL    = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS  = 8'h04;
	localparam logic [AXI_AW-1:0] REG_INT_ST  = 8'h08;
	localparam logic [AXI_AW-1:0] REG_INT_CLR = 8'h0C;
	localparam logic [AXI_AW-1:0] REG_INT_EN  = 8'h10;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic [AXI_DW-1:0] CTRL_RESET = 32'h00000001;
	// Interrupt event bits
	localparam int EV_W        = 4;
	localparam int EV_OC       = 0;
	localparam int EV_THERM    = 1;
	localparam int EV_PG_RISE  = 2;
	localparam int EV_SUPPLY   = 3;
	localparam logic [EV_W-1:0] INT_EN_RESET = 4'h0;
	// Synchronised pin vector positions
	localparam int PIN_W       = 7;
	localparam int PIN_LOW     = 0;
	localparam int PIN_HIGH    = 1;
	localparam int PIN_LOCK    = 2;
	localparam int PIN_CUR     = 3;
	localparam int PIN_TRIP    = 4;
	localparam int PIN_COOL    = 5;
	localparam int PIN_DRAIN   = 6;
	// Supervisor states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ON,
		ST_DELAY,
		ST_LATCH
	} hsfs_state_t;
endpackage : hsfs_pkg

// file: hw/hsfs_supervisor.sv
// Purpose: Digital supervisor of a negative-rail hot-swap controller
// Assumes: Comparator outputs arrive asynchronously; 100 MHz clock
// Notes:   Registers reached over AXI4-Lite
// What this block does
// R1: Drive on only with supply window, current OK
// R2: Any fault drops the drive at once
// R3: Integrator steps once per tick during overcurrent
// R4: Sub-tick overcurrent counts as a full step
// R5: Reaching limit duration declares overcurrent fault
// R6: Integrator decays 128 times slower than rising
// R7: Pulses above 1/128 duty end in fault
// R8: Temperature trip turns drive off as fault
// R9: Autoretry waits cool-down after thermal fault
// R10: Autoretry restarts only after temperature falls
// R11: Latched variant holds off until low-supply pulse
// R12: Latch clear still waits cool-down time
// R13: Autoretry restarts after restart delay by itself
// R14: Latched breaker clears by pulse, then delay
// R15: Power-ok stays asserted through overvoltage faults
// R16: Static variant parameters select behaviour
// R17: Integrator floors at zero, clears on fault
`timescale 1ns/1ps
module hsfs_supervisor #(
	parameter bit AUTORETRY      = 1'b1, // [R16]
	parameter bit LONG_LIMIT     = 1'b0,
	parameter bit PG_ACTIVE_HIGH = 1'b0,
	parameter int TICK_LONG_CYC  = hsfs_pkg::TICK_LONG_CYC,
	parameter int COOL_CYC       = hsfs_pkg::COOL_CYC,
	parameter int RESTART_CYC    = hsfs_pkg::RESTART_CYC
) (
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic                           lowSupplyDetect,
	input  wire logic                           highSupplyDetect,
	input  wire logic                           supplyLockout,
	input  wire logic                           currentLimitTrip,
	input  wire logic                           thermTrip,
	input  wire logic                           thermCool,
	input  wire logic                           drainLow,
	output logic                                fetDrive,
	output logic                                powerOkOutput,
	output logic                                irq,
	input  wire logic [hsfs_pkg::AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [hsfs_pkg::AXI_DW-1:0]    s_axi_wdata,
	input  wire logic [hsfs_pkg::AXI_DW/8-1:0]  s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [hsfs_pkg::AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [hsfs_pkg::AXI_DW-1:0]         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);
	import hsfs_pkg::*;

	localparam int TICK_CYC = LONG_LIMIT ? TICK_LONG_CYC : TICK_SHORT_CYC;

	logic [PIN_W-1:0]   pinMeta;
	logic [PIN_W-1:0]   pinSync;
	logic               startOk;
	logic               runOk;
	logic               pgRaw;
	logic               pgFlag;
	logic               faultThermal;
	logic               seenLow;
	logic [TIMER_W-1:0] timer;
	hsfs_state_t        state;
	logic [AXI_DW-1:0]  ctrl;
	logic [EV_W-1:0]    intStatus;
	logic [EV_W-1:0]    intEnable;
	logic [EV_W-1:0]    events;
	logic [AXI_AW-1:0]  awAddr;
	logic [AXI_DW-1:0]  wData;
	logic [AXI_DW/8-1:0] wStrb;
	logic               doWrite;
	logic [EV_W-1:0]    clrMask;
	logic [AXI_DW-1:0]  statusWord;

	hsfs_oc_if ocBus ();

	// Merge write data into a register under byte strobes
	function automatic logic [AXI_DW-1:0] mergeBytes(
		input logic [AXI_DW-1:0]   old,
		input logic [AXI_DW-1:0]   data,
		input logic [AXI_DW/8-1:0] strb
	);
		logic [AXI_DW-1:0] res;
		res = old;
		for (int i = 0; i < AXI_DW / 8; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	// Two flip-flops on every comparator pin
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {drainLow, thermCool, thermTrip, currentLimitTrip,
				supplyLockout, highSupplyDetect, lowSupplyDetect};
			pinSync <= pinMeta;
		end
	end

	// Run window: in range, above lockout, cool die; overcurrent alone is regulated, not a fault
	assign runOk = pinSync[PIN_LOW] && !pinSync[PIN_HIGH] && !pinSync[PIN_LOCK]
		&& !pinSync[PIN_TRIP] && ctrl[CTRL_ENABLE_BIT]; // [R1] [R2]
	// Startup also needs the shunt under its trip level
	assign startOk = runOk && !pinSync[PIN_CUR]; // [R1]

	// Overcurrent integrator runs on the synchronised trip comparator
	assign ocBus.overCurrent = pinSync[PIN_CUR];
	assign ocBus.clear = (state != ST_ON) && (state != ST_IDLE);

	hsfs_oc_integrator #(
		.TICK_CYC (TICK_CYC)
	) u_integ (
		.clk   (clk),
		.rst_b (rst_b),
		.oc    (ocBus.integ)
	);

	// Main sequencer; thermal trip takes priority over breaker fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			timer <= '0;
			faultThermal <= 1'b0;
			seenLow <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (startOk) begin
						state <= ST_ON;
					end
				end
				ST_ON: begin
					if (pinSync[PIN_TRIP]) begin
						faultThermal <= 1'b1; // [R8]
						timer <= TIMER_W'(COOL_CYC); // [R9]
						state <= AUTORETRY ? ST_DELAY : ST_LATCH; // [R11]
						seenLow <= 1'b0;
					end else if (ocBus.fault) begin
						faultThermal <= 1'b0;
						timer <= TIMER_W'(RESTART_CYC); // [R13]
						state <= AUTORETRY ? ST_DELAY : ST_LATCH; // [R14]
						seenLow <= 1'b0;
					end else if (!runOk) begin
						state <= ST_IDLE; // [R2]
					end
				end
				ST_LATCH: begin
					// Only a low pulse on the low-supply detect releases the latch
					if (!pinSync[PIN_LOW]) begin
						seenLow <= 1'b1;
					end
					if (seenLow && pinSync[PIN_LOW]) begin
						timer <= faultThermal ? TIMER_W'(COOL_CYC) : TIMER_W'(RESTART_CYC); // [R12] [R14]
						state <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (timer != '0) begin
						timer <= timer - 1'b1;
					end else if (!faultThermal || !AUTORETRY || pinSync[PIN_COOL]) begin
						state <= ST_IDLE; // [R9] [R10] [R13]
						faultThermal <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Gate drive; in ON it drops the cycle any fault is seen
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fetDrive <= 1'b0;
		end else begin
			fetDrive <= (state == ST_ON) && runOk && !ocBus.fault; // [R1] [R2] [R5]
		end
	end

	// Power-good latch; overvoltage alone does not clear it
	assign pgRaw = fetDrive && pinSync[PIN_DRAIN];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pgFlag <= 1'b0;
		end else if (!pinSync[PIN_LOW] || pinSync[PIN_LOCK] || state == ST_DELAY
			|| state == ST_LATCH || !ctrl[CTRL_ENABLE_BIT]) begin
			pgFlag <= 1'b0;
		end else if (pgRaw) begin
			pgFlag <= 1'b1; // [R15]
		end
	end

	// Output polarity chosen by variant; reset shows the inactive level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			powerOkOutput <= !PG_ACTIVE_HIGH;
		end else begin
			powerOkOutput <= PG_ACTIVE_HIGH ? pgFlag : !pgFlag; // [R16]
		end
	end

	// Events for the interrupt status
	always_comb begin
		events = '0;
		events[EV_OC] = ocBus.fault;
		events[EV_THERM] = (state == ST_ON) && pinSync[PIN_TRIP];
		events[EV_PG_RISE] = pgRaw && !pgFlag;
		events[EV_SUPPLY] = (state == ST_ON) && !runOk && !pinSync[PIN_TRIP];
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			awAddr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awAddr <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_wready <= 1'b1;
			wData <= '0;
			wStrb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write executes once both halves are held
	assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			case (awAddr)
				REG_CTRL, REG_INT_CLR, REG_INT_EN: s_axi_bresp <= RESP_OKAY;
				REG_STATUS, REG_INT_ST: s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control and interrupt enable registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= CTRL_RESET;
			intEnable <= INT_EN_RESET;
		end else if (doWrite && awAddr == REG_CTRL) begin
			ctrl <= mergeBytes(ctrl, wData, wStrb) & CTRL_RESET;
		end else if (doWrite && awAddr == REG_INT_EN) begin
			intEnable <= EV_W'(mergeBytes({{(AXI_DW-EV_W){1'b0}}, intEnable}, wData, wStrb));
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	assign clrMask = (doWrite && awAddr == REG_INT_CLR && wStrb[0]) ? wData[EV_W-1:0] : '0;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			intStatus <= '0;
		end else begin
			intStatus <= (intStatus & ~clrMask) | events;
		end
	end

	// Level interrupt, registered
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(intStatus & intEnable);
		end
	end

	// Live state word
	always_comb begin
		statusWord = '0;
		statusWord[0] = fetDrive;
		statusWord[1] = pgFlag;
		statusWord[3:2] = state;
		statusWord[8:4] = ocBus.count;
		statusWord[9] = faultThermal;
		statusWord[16:10] = pinSync;
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL: s_axi_rdata <= ctrl;
				REG_STATUS: s_axi_rdata <= statusWord;
				REG_INT_ST: s_axi_rdata <= {{(AXI_DW-EV_W){1'b0}}, intStatus};
				REG_INT_EN: s_axi_rdata <= {{(AXI_DW-EV_W){1'b0}}, intEnable};
				REG_INT_CLR: s_axi_rdata <= '0;
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : hsfs_supervisor

// file: verif/hsfs_plant_model.sv
// Purpose: Comparators and pass device seen by the supervisor
// Assumes: Knobs come from the bench
// Notes:   Drain and temperature respond with lag
`timescale 1ns/1ps
module hsfs_plant_model #(
	parameter int DRAIN_LAG = 4,
	parameter int COOL_LAG  = 200
) (
	input wire logic clk,
	input wire logic fetDrive,
	input wire logic supplyOk,
	input wire logic overVolt,
	input wire logic lockOut,
	input wire logic overCur,
	input wire logic hot,
	output logic     lowSupplyDetect,
	output logic     highSupplyDetect,
	output logic     supplyLockout,
	output logic     currentLimitTrip,
	output logic     thermTrip,
	output logic     thermCool,
	output logic     drainLow
);
	int drainCnt = 0;
	int coolCnt  = 0;
	// Comparator levels
	assign lowSupplyDetect  = supplyOk;
	assign highSupplyDetect = overVolt;
	assign supplyLockout    = lockOut;
	assign currentLimitTrip = overCur;
	assign thermTrip        = hot;
	assign thermCool        = coolCnt >= COOL_LAG;
	assign drainLow         = drainCnt >= DRAIN_LAG;
	// Die cools slower than the cool-down timer, so both gates are visible
	always_ff @(posedge clk) begin
		drainCnt <= fetDrive ? (drainLow ? drainCnt : drainCnt + 1) : 0;
		coolCnt  <= hot ? 0 : (thermCool ? coolCnt : coolCnt + 1);
	end
endmodule : hsfs_plant_model

// file: verif/hsfs_supervisor_properties.sv
// Purpose: Port checks of the hot-swap fault supervisor
// Assumes: One clock, synchronous active-low reset
// Notes:   Pins take 3 edges to reach the drive; checks allow 5
`timescale 1ns/1ps
module hsfs_supervisor_properties
	import hsfs_pkg::*;
#(
	parameter int TICK_CYC       = 64,
	parameter bit PG_ACTIVE_HIGH = 1'h0
) (
	input wire logic                        clk,
	input wire logic                        rst_b,
	input wire logic                        lowSupplyDetect,
	input wire logic                        highSupplyDetect,
	input wire logic                        supplyLockout,
	input wire logic                        currentLimitTrip,
	input wire logic                        thermTrip,
	input wire logic                        fetDrive,
	input wire logic                        powerOkOutput,
	input wire logic                        s_axi_awready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_bready,
	input wire logic [1:0]                  s_axi_bresp,
	input wire logic                        s_axi_rvalid,
	input wire logic                        s_axi_rready,
	input wire logic [hsfs_pkg::AXI_DW-1:0] s_axi_rdata
);
	// Longest overcurrent the breaker may allow, with two ticks of slack for phase
	localparam int OC_BOUND = (LIMIT_TICKS + 2) * TICK_CYC + 8;
	int   ocRun;
	logic pgOn;
	assign pgOn = (powerOkOutput == PG_ACTIVE_HIGH);
	// Run length of overcurrent, held just past the bound
	always_ff @(posedge clk) begin
		if (!rst_b || !currentLimitTrip)
			ocRun <= 0;
		else if (ocRun <= OC_BOUND)
			ocRun <= ocRun + 1;
	end
	// Supply fine except for overvoltage
	sequence ovOnly;
		highSupplyDetect && lowSupplyDetect && !supplyLockout && !thermTrip && !currentLimitTrip;
	endsequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_low_supply_off: assert property (!lowSupplyDetect [*5] |-> !fetDrive)
		else $error("drive on with low supply");
	a_over_volt_off: assert property (highSupplyDetect [*5] |-> !fetDrive)
		else $error("drive on in overvoltage");
	a_lockout_off: assert property (supplyLockout [*5] |-> !fetDrive)
		else $error("drive on in lockout");
	a_therm_off: assert property (thermTrip [*5] |-> !fetDrive)
		else $error("drive on at thermal trip");
	a_breaker_trips: assert property (ocRun > OC_BOUND |-> !fetDrive)
		else $error("breaker did not trip");
	a_pg_holds_ov: assert property (ovOnly [*4] ##0 pgOn |=> pgOn)
		else $error("power ok dropped by overvoltage");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response withdrawn");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data withdrawn");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
endmodule : hsfs_supervisor_properties

bind hsfs_supervisor hsfs_supervisor_properties #(
	.TICK_CYC(LONG_LIMIT ? TICK_LONG_CYC : hsfs_pkg::TICK_SHORT_CYC), .PG_ACTIVE_HIGH(PG_ACTIVE_HIGH)
) chk_u (.*);

// file: verif/tb_top.sv
// Purpose: Self-checking bench of the hot-swap fault supervisor
// Assumes: Long limit, short delays; main device autoretry with active-low power ok, second one latched
// Notes:   Waits are bounded; a hang ends the run as a failure
`timescale 1ns/1ps
module tb_top;
	import hsfs_pkg::*;
	localparam int TICK  = 64;
	localparam int DELAY = 50;
	logic                clk = 1'h0;
	logic                rst_b = 1'h0;
	logic                supplyOk = 1'h0;
	logic                overVolt = 1'h0;
	logic                lockOut = 1'h1;
	logic                overCur = 1'h0;
	logic                hot = 1'h0;
	logic [AXI_AW-1:0]   s_axi_awaddr = 8'h00;
	logic [AXI_AW-1:0]   s_axi_araddr = 8'h00;
	logic [AXI_DW-1:0]   s_axi_wdata = 32'h0;
	logic [AXI_DW/8-1:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetDrive, powerOkOutput, irq;
	logic lowSupplyDetect, highSupplyDetect, supplyLockout, currentLimitTrip, thermTrip, thermCool, drainLow;
	logic [1:0]          s_axi_bresp, s_axi_rresp, r;
	logic [AXI_DW-1:0]   s_axi_rdata, q;
	int                  error_cnt = 0;
	int                  samples_checked = 0;
	int                  i;
	logic                fetDriveLatched, powerOkLatched;
	always #5 clk = ~clk;
	hsfs_supervisor #(.AUTORETRY(1'h1), .LONG_LIMIT(1'h1), .PG_ACTIVE_HIGH(1'h0), .TICK_LONG_CYC(TICK),
		.COOL_CYC(DELAY), .RESTART_CYC(DELAY)) dut_u (.*);
	hsfs_plant_model #(.DRAIN_LAG(4), .COOL_LAG(200)) plant_u (.*);
	// Second device, latched with active-high power ok, on the same pins and bus
	hsfs_supervisor #(.AUTORETRY(1'h0), .LONG_LIMIT(1'h1), .PG_ACTIVE_HIGH(1'h1), .TICK_LONG_CYC(TICK),
		.COOL_CYC(DELAY), .RESTART_CYC(DELAY)) dut_latch (.*, .fetDrive(fetDriveLatched),
		.powerOkOutput(powerOkLatched), .irq(), .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid());
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [AXI_DW-1:0] seen, input logic [AXI_DW-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	// One AXI4-Lite transfer; each channel released at its own handshake
	task automatic bus(input logic wr, input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (wr ? s_axi_bvalid : s_axi_rvalid) break;
		end
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		if (n == 64) begin
			chk("bus answer", 32'h0, 32'h1);
			tally_and_finish();
		end
		@(posedge clk);
	endtask : bus
	task automatic wait_fet(input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim && fetDrive !== lvl; n++)
			@(posedge clk);
		chk("fetDrive", fetDrive, lvl);
		if (fetDrive !== lvl) tally_and_finish();
	endtask : wait_fet
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		bus(0, REG_CTRL, 0);
		chk("ctrl", q, CTRL_RESET);
		bus(0, REG_INT_EN, 0);
		chk("int_en", q, INT_EN_RESET);
		bus(0, 8'h14, 0);
		chk("hole rdata", q, 32'h0);
		chk("hole rresp", r, RESP_SLVERR);
		bus(1, 8'h14, 32'h1);
		chk("hole bresp", r, RESP_SLVERR);
		bus(1, REG_INT_EN, 32'h3);
		bus(0, REG_INT_EN, 0);
		chk("int_en", q, 32'h3);
		$display("test registers done");
		supplyOk <= 1'h1;
		lockOut <= 1'h0;
		wait_fet(1, 20);
		repeat (12) @(posedge clk);
		chk("powerOk", powerOkOutput, 0);
		// Each bad supply condition in turn; only overvoltage keeps power ok
		for (i = 0; i < 3; i++) begin
			supplyOk <= (i != 0);
			overVolt <= (i == 1);
			lockOut <= (i == 2);
			wait_fet(0, 8);
			repeat (4) @(posedge clk);
			chk("powerOk", powerOkOutput, i != 1);
			supplyOk <= 1'h1;
			overVolt <= 1'h0;
			lockOut <= 1'h0;
			wait_fet(1, 4 * DELAY);
			repeat (12) @(posedge clk); // Power ok must be up before the next condition
		end
		chk("irq masked", irq, 0);
		bus(0, REG_INT_ST, 0);
		chk("supply event", q[EV_SUPPLY], 1);
		$display("test supply window done");
		overCur <= 1'h1;
		@(posedge clk);
		overCur <= 1'h0;
		repeat (2 * TICK + 8) @(posedge clk);
		bus(0, REG_STATUS, 0);
		chk("count", q[8:4], 1);
		repeat (64 * TICK) @(posedge clk);
		bus(0, REG_STATUS, 0);
		chk("count", q[8:4], 1);
		repeat (67 * TICK) @(posedge clk);
		bus(0, REG_STATUS, 0);
		chk("count", q[8:4], 0);
		$display("test pulse decay done");
		bus(1, REG_INT_CLR, 32'hF);
		hot <= 1'h1;
		wait_fet(0, 8);
		repeat (20) @(posedge clk);
		chk("irq", irq, 1);
		hot <= 1'h0;
		repeat (120) @(posedge clk);
		chk("fetDrive", fetDrive, 0);
		wait_fet(1, 300);
		bus(1, REG_INT_CLR, 32'h2);
		chk("irq", irq, 0);
		chk("latched fet", fetDriveLatched, 0);
		// A low pulse on the low-supply detect releases the latch, then cool-down runs
		supplyOk <= 1'h0;
		repeat (8) @(posedge clk);
		supplyOk <= 1'h1;
		repeat (30) @(posedge clk);
		chk("latched fet", fetDriveLatched, 0);
		for (i = 0; i < 100 && fetDriveLatched !== 1'h1; i++)
			@(posedge clk);
		chk("latched fet", fetDriveLatched, 1);
		repeat (16) @(posedge clk);
		chk("latched powerOk", powerOkLatched, 1);
		$display("test thermal done");
		overCur <= 1'h1;
		repeat (14 * TICK) @(posedge clk);
		chk("fetDrive", fetDrive, 1);
		wait_fet(0, 4 * TICK);
		bus(0, REG_INT_ST, 0);
		chk("oc event", q[EV_OC], 1);
		bus(0, REG_STATUS, 0);
		chk("count", q[8:4], 0);
		overCur <= 1'h0;
		wait_fet(1, 4 * DELAY);
		chk("latched fet", fetDriveLatched, 0);
		bus(1, REG_INT_CLR, 32'h1);
		$display("test breaker done");
		// One tick in 32 is above the allowed duty, so the breaker must trip
		for (i = 0; i < 30 && irq !== 1'h1; i++) begin
			overCur <= 1'h1;
			@(posedge clk);
			overCur <= 1'h0;
			repeat (32 * TICK) @(posedge clk);
		end
		chk("irq", irq, 1);
		$display("test duty done");
		tally_and_finish();
	end
endmodule : tb_top
